// ### logic/bcs_sequencer.sv
// Purpose: Charge state sequence, safety timers and status pins of a Li-cell charger
// Assumes: Comparator and pin inputs are asynchronous and synchronised here
// Notes: Avalon-MM slave with one wait state; variants chosen by a control register
`timescale 1ns/1ns
// What this block does
// R01: Status pins are open-drain; asserted means pulled low, deasserted means released.
// R02: Status pair encodes off/suspend, charging, done, bad battery or regulator mode.
// R03: Three independent safety timers can each force charging to end.
// R04: Preconditioning over 30 minutes without reaching full rate gives bad battery.
// R05: Full-rate phase over 5 hours without end-of-charge gives bad battery.
// R06: Bad battery stays latched until the supply is removed.
// R07: Top-off runs 30 minutes or until current falls to 2.5 percent.
// R08: Top-off expiry counts as success and leads to done, never bad.
// R09: Suspend or disable freezes the active timer; it resumes in the same phase.
// R10: Timer variant: low select gives 10 hours and 60 minutes, high 5 and 30.
// R11: Select sets current and timers from USB, only timers from wall adapter.
// R12: Temperature out of window suspends charging, releases both pins, holds timer.
// R13: Without regulator variant a floating thermistor means too hot and suspends.
// R14: Host drives disable high to interrupt; device holds timer and releases pins.
// R15: Regulator variant: floating thermistor with wall adapter gives regulator mode.
// R16: Regulator mode is never entered while USB is the charging source.
// R17: Disable and current-select inputs are accepted after about 40 ms stable.
// R18: With both supplies valid, the wall adapter is the charging source.
// R19: A recharge from maintenance resets the timers and shows charging again.
// R20: Safety timers count ticks of a prescaler on the internal clock.
module bcs_sequencer #(
   parameter int MINUTE_CYCLES = bcs_pkg::MINUTE_CYC,
   parameter int FILTER_CYCLES = bcs_pkg::DEBOUNCE_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire bcs_pkg::bcs_sense_s sense,
   input wire logic disable_pin,
   input wire logic current_select,
   output logic status_out_a,
   output logic status_out_a_oe,
   output logic status_out_b,
   output logic status_out_b_oe,
   output logic charge_on,
   output logic regulator_mode,
   output logic usb_high_current,
   output logic source_is_usb,
   output bcs_pkg::bcs_phase_e charge_phase,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   bcs_pkg::bcs_seq_s st;
   bcs_pkg::bcs_seq_s next_st;
   logic dis_f;
   logic sel_f;
   logic wall;
   logic usb;
   logic any_src;
   logic temp_bad;
   logic ldo_cond;
   logic paused;
   logic timer_long;
   logic [bcs_pkg::TMR_W-1:0] fr_limit;
   logic [bcs_pkg::TMR_W-1:0] top_limit;
   logic pre_exp;
   logic fr_exp;
   logic top_exp;
   logic [bcs_pkg::TMR_W-1:0] fr_count;
   logic in_fr;

   // R17: filtered host pins
   bcs_debounce #(.LIMIT(FILTER_CYCLES)) u_dis_filter (
      .core_clk(core_clk),
      .reset(reset),
      .pin(disable_pin),
      .level(dis_f)
   );
   bcs_debounce #(.LIMIT(FILTER_CYCLES)) u_sel_filter (
      .core_clk(core_clk),
      .reset(reset),
      .pin(current_select),
      .level(sel_f)
   );

   // Source, temperature and pause decode from synced sense
   always_comb
   begin
      wall = st.sync2.wall_ok;
      // R18: wall adapter priority
      usb = st.sync2.bus_ok && !wall;
      any_src = wall || st.sync2.bus_ok;
      // R13: floating thermistor reads as hot
      temp_bad = st.sync2.temp_hot || st.sync2.temp_cold || st.sync2.ts_float;
      // R15: regulator mode condition
      // R16: requires the wall adapter
      ldo_cond = st.ctrl[bcs_pkg::CTRL_REG_VARIANT] && st.sync2.ts_float && wall;
      // R12: temperature suspend
      // R14: host disable
      paused = dis_f || temp_bad;
      in_fr = (st.phase == bcs_pkg::PH_CC) || (st.phase == bcs_pkg::PH_CV);
   end

   // R10: timer lengths from the filtered select pin
   // R11: select steers timers on either source
   always_comb
   begin
      timer_long = st.ctrl[bcs_pkg::CTRL_TMR_VARIANT] && !sel_f;
      fr_limit = timer_long ? bcs_pkg::FULLRATE_LONG_MIN : bcs_pkg::FULLRATE_MIN;
      top_limit = timer_long ? bcs_pkg::TOPOFF_LONG_MIN : bcs_pkg::TOPOFF_MIN;
   end

   // R03: three independent safety timers
   // R09: each runs only in its own unpaused phase, cleared outside it
   bcs_timer u_pre_timer (
      .core_clk(core_clk),
      .reset(reset),
      .tick(st.tick),
      .run(st.phase == bcs_pkg::PH_PRE && !paused),
      .clear(st.phase != bcs_pkg::PH_PRE),
      .limit(bcs_pkg::PRECOND_MIN),
      .expired(pre_exp),
      .count()
   );
   bcs_timer u_fr_timer (
      .core_clk(core_clk),
      .reset(reset),
      .tick(st.tick),
      .run(in_fr && !paused),
      .clear(!in_fr),
      .limit(fr_limit),
      .expired(fr_exp),
      .count(fr_count)
   );
   bcs_timer u_top_timer (
      .core_clk(core_clk),
      .reset(reset),
      .tick(st.tick),
      .run(st.phase == bcs_pkg::PH_TOP && !paused),
      .clear(st.phase != bcs_pkg::PH_TOP),
      .limit(top_limit),
      .expired(top_exp),
      .count()
   );

   // Next state: sync, prescaler, phase, outputs, bus
   always_comb
   begin
      next_st = st;
      next_st.sync1 = sense;
      next_st.sync2 = st.sync1;
      // R20: minute prescaler
      next_st.tick = 1'b0;
      if (st.presc == bcs_pkg::PRESC_W'(MINUTE_CYCLES - 1))
      begin
         next_st.presc = '0;
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.presc = st.presc + 1'b1;
      end

      // R06: loss of supply is the only exit from bad battery
      if (!any_src)
      begin
         next_st.phase = bcs_pkg::PH_OFF;
      end
      else
      begin
         unique case (st.phase)
            bcs_pkg::PH_OFF:
               next_st.phase = ldo_cond ? bcs_pkg::PH_REG : bcs_pkg::PH_PRE;
            bcs_pkg::PH_BAD:
               next_st.phase = bcs_pkg::PH_BAD;
            bcs_pkg::PH_REG:
               if (!ldo_cond)
                  next_st.phase = bcs_pkg::PH_PRE;
            bcs_pkg::PH_PRE:
               if (ldo_cond)
                  next_st.phase = bcs_pkg::PH_REG;
               // R04: preconditioning timeout
               else if (!paused && pre_exp)
                  next_st.phase = bcs_pkg::PH_BAD;
               else if (!paused && st.sync2.above_fullrate)
                  next_st.phase = bcs_pkg::PH_CC;
            bcs_pkg::PH_CC:
               if (ldo_cond)
                  next_st.phase = bcs_pkg::PH_REG;
               // R05: full-rate timeout
               else if (!paused && fr_exp)
                  next_st.phase = bcs_pkg::PH_BAD;
               else if (!paused && st.sync2.at_term)
                  next_st.phase = bcs_pkg::PH_CV;
            bcs_pkg::PH_CV:
               if (ldo_cond)
                  next_st.phase = bcs_pkg::PH_REG;
               else if (!paused && fr_exp)
                  next_st.phase = bcs_pkg::PH_BAD;
               else if (!paused && st.sync2.eoc_reached)
                  next_st.phase = bcs_pkg::PH_TOP;
            bcs_pkg::PH_TOP:
               if (ldo_cond)
                  next_st.phase = bcs_pkg::PH_REG;
               // R07: top-off ends on current or timer
               // R08: expiry means done
               else if (!paused && (top_exp || st.sync2.topoff_current))
                  next_st.phase = bcs_pkg::PH_DONE;
            bcs_pkg::PH_DONE:
               if (ldo_cond)
                  next_st.phase = bcs_pkg::PH_REG;
               // R19: recharge restarts full-rate with fresh timers
               else if (!paused && st.sync2.batt_sagged)
                  next_st.phase = bcs_pkg::PH_CC;
         endcase
      end

      // R02: status encoding per phase
      // R12: suspend releases both pins
      next_st.out_a_oe = 1'b0;
      next_st.out_b_oe = 1'b0;
      next_st.charge_on = 1'b0;
      unique case (next_st.phase)
         bcs_pkg::PH_PRE, bcs_pkg::PH_CC, bcs_pkg::PH_CV, bcs_pkg::PH_TOP:
         begin
            next_st.out_a_oe = !paused;
            next_st.charge_on = !paused;
         end
         bcs_pkg::PH_DONE:
            next_st.out_b_oe = !paused;
         bcs_pkg::PH_BAD, bcs_pkg::PH_REG:
         begin
            next_st.out_a_oe = 1'b1;
            next_st.out_b_oe = 1'b1;
         end
         bcs_pkg::PH_OFF:
            next_st.charge_on = 1'b0;
      endcase
      next_st.reg_on = (next_st.phase == bcs_pkg::PH_REG);
      next_st.src_usb = usb;
      // R11: select sets current only from USB
      next_st.usb_high = usb && sel_f;

      // Avalon slave: one wait state, data loaded with the ack
      next_st.ack = (avs_read || avs_write) && !st.ack;
      if (avs_read && !st.ack)
      begin
         unique case (avs_address)
            bcs_pkg::REG_CTRL:
               next_st.rdata = {30'h0, st.ctrl};
            bcs_pkg::REG_STATUS:
               next_st.rdata = {20'h0, timer_long, st.sync2.ts_float, dis_f, temp_bad, sel_f,
                                st.src_usb, wall, st.sync2.bus_ok, 1'b0, st.phase};
            default:
               next_st.rdata = 32'h0;
         endcase
      end
      if (avs_write && st.ack && avs_address == bcs_pkg::REG_CTRL && avs_byteenable[0])
      begin
         next_st.ctrl = avs_writedata[1:0];
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         st <= '0;
         st.ctrl <= bcs_pkg::CTRL_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // R01: open-drain pins drive only low
   assign status_out_a = 1'b0;
   assign status_out_b = 1'b0;
   assign status_out_a_oe = st.out_a_oe;
   assign status_out_b_oe = st.out_b_oe;
   assign charge_on = st.charge_on;
   assign regulator_mode = st.reg_on;
   assign usb_high_current = st.usb_high;
   assign source_is_usb = st.src_usb;
   assign charge_phase = st.phase;
   assign avs_readdata = st.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !st.ack;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_live;
      any_src && !ldo_cond && !paused;
   endsequence

   // Rule checks: pin encoding, suspend, timeouts, latching, sources and bus wait state
   a_bad_both_on: assert property (st.phase == bcs_pkg::PH_BAD ##1 st.phase == bcs_pkg::PH_BAD
                                   |-> status_out_a_oe && status_out_b_oe) // R02
      else $error("bad battery without both pins asserted");
   a_pause_release: assert property (paused && any_src && !ldo_cond && st.phase != bcs_pkg::PH_BAD
                                     |=> !status_out_a_oe && !status_out_b_oe) // R12
      else $error("pins not released in suspend");
   a_pre_timeout: assert property (st.phase == bcs_pkg::PH_PRE && pre_exp and s_live
                                   |=> st.phase == bcs_pkg::PH_BAD && status_out_a_oe && status_out_b_oe) // R04
      else $error("preconditioning timeout missed");
   a_fr_timeout: assert property (in_fr && fr_exp and s_live |=> st.phase == bcs_pkg::PH_BAD) // R05
      else $error("full-rate timeout missed");
   a_bad_latched: assert property (st.phase == bcs_pkg::PH_BAD && any_src |=> st.phase == bcs_pkg::PH_BAD) // R06
      else $error("bad battery cleared with supply present");
   a_top_done: assert property (st.phase == bcs_pkg::PH_TOP && top_exp and s_live
                                |=> st.phase == bcs_pkg::PH_DONE && !status_out_a_oe && status_out_b_oe) // R08
      else $error("top-off expiry did not give done");
   a_no_reg_usb: assert property (st.phase == bcs_pkg::PH_REG |-> $past(wall)) // R16
      else $error("regulator mode without wall adapter");
   a_recharge_reset: assert property (st.phase == bcs_pkg::PH_DONE && st.sync2.batt_sagged and s_live
                                      |=> st.phase == bcs_pkg::PH_CC && fr_count == '0) // R19
      else $error("recharge did not restart timers");
   a_wall_priority: assert property (wall |=> !source_is_usb) // R18
      else $error("USB chosen with wall adapter present");
   a_one_wait: assert property (avs_read && !st.ack |=> !avs_waitrequest) // bus answer after one wait state
      else $error("bus answer late");
endmodule : bcs_sequencer

// ### logic/bcs_pkg.sv
// Purpose: Shared constants and types of the battery charge sequencer
// Assumes: 20 MHz core clock, synchronous active-high reset
// Notes: Times kept in their own units; cycle counts derived here
package bcs_pkg;
   // Clock and time bases
   localparam int CLK_HZ = 20_000_000;
   localparam int MINUTE_S = 60;
   localparam int MINUTE_CYC = MINUTE_S * CLK_HZ;
   localparam int DEBOUNCE_MS = 40;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);

   // Safety timer lengths in minutes
   localparam int TMR_W = 10;
   localparam logic [TMR_W-1:0] PRECOND_MIN = 10'(30);
   localparam logic [TMR_W-1:0] FULLRATE_MIN = 10'(5 * 60);
   localparam logic [TMR_W-1:0] FULLRATE_LONG_MIN = 10'(10 * 60);
   localparam logic [TMR_W-1:0] TOPOFF_MIN = 10'(30);
   localparam logic [TMR_W-1:0] TOPOFF_LONG_MIN = 10'(60);

   // Register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_TMR_VARIANT = 0;
   localparam int CTRL_REG_VARIANT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Widths of counters
   localparam int PRESC_W = 31;
   localparam int DBN_W = 20;

   // Charge phases, Gray codes along the charge path
   typedef enum logic [2:0] {
      PH_OFF = 3'h0,
      PH_PRE = 3'h1,
      PH_CC = 3'h3,
      PH_CV = 3'h2,
      PH_TOP = 3'h6,
      PH_DONE = 3'h7,
      PH_BAD = 3'h5,
      PH_REG = 3'h4
   } bcs_phase_e;

   // Comparator and supply qualification inputs
   typedef struct packed {
      logic wall_ok;
      logic bus_ok;
      logic temp_hot;
      logic temp_cold;
      logic ts_float;
      logic above_fullrate;
      logic at_term;
      logic eoc_reached;
      logic topoff_current;
      logic batt_sagged;
   } bcs_sense_s;

   // Sequencer state
   typedef struct packed {
      bcs_sense_s sync1;
      bcs_sense_s sync2;
      bcs_phase_e phase;
      logic [PRESC_W-1:0] presc;
      logic tick;
      logic out_a_oe;
      logic out_b_oe;
      logic charge_on;
      logic reg_on;
      logic usb_high;
      logic src_usb;
      logic [1:0] ctrl;
      logic ack;
      logic [31:0] rdata;
   } bcs_seq_s;

   // Safety timer state
   typedef struct packed {
      logic [TMR_W-1:0] count;
   } bcs_tmr_s;

   // Input filter state
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic stable;
      logic [DBN_W-1:0] cnt;
   } bcs_dbn_s;
endpackage : bcs_pkg

// ### logic/bcs_debounce.sv
// Purpose: Synchronise a pin and accept a level only after it holds
// Assumes: LIMIT below 2**20 cycles
// Notes: Output starts low after reset
`timescale 1ns/1ns
module bcs_debounce #(
   parameter int LIMIT = bcs_pkg::DEBOUNCE_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic pin,
   output logic level
);
   bcs_pkg::bcs_dbn_s st;
   bcs_pkg::bcs_dbn_s next_st;

   // Count how long the synced level differs from the accepted one
   always_comb
   begin
      next_st = st;
      next_st.sync1 = pin;
      next_st.sync2 = st.sync1;
      if (st.sync2 == st.stable)
      begin
         next_st.cnt = '0;
      end
      else if (st.cnt == bcs_pkg::DBN_W'(LIMIT - 1))
      begin
         next_st.stable = st.sync2;
         next_st.cnt = '0;
      end
      else
      begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign level = st.stable;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_filter_hold: assert property ($changed(st.stable) |-> $past(st.cnt) == bcs_pkg::DBN_W'(LIMIT - 1)) // R17
      else $error("filtered level changed before hold time");
endmodule : bcs_debounce

// ### logic/bcs_timer.sv
// Purpose: One safety timer counting minute ticks
// Assumes: Clear wins over counting
// Notes: Count freezes whenever run and clear are both low
`timescale 1ns/1ns
module bcs_timer (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [bcs_pkg::TMR_W-1:0] limit,
   output logic expired,
   output logic [bcs_pkg::TMR_W-1:0] count
);
   bcs_pkg::bcs_tmr_s st;
   bcs_pkg::bcs_tmr_s next_st;

   // Count ticks while running, saturate at the limit
   always_comb
   begin
      next_st = st;
      if (clear)
         next_st.count = '0;
      else if (run && tick && st.count < limit)
         next_st.count = st.count + 1'b1;
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign count = st.count;
   assign expired = (st.count >= limit);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_freeze_count: assert property (!run && !clear |=> $stable(st.count)) // R09
      else $error("timer moved while frozen");
endmodule : bcs_timer

// ### test/bcs_host_model.sv
// Purpose: Status pin pull-ups and battery thermistor seen from the board
// Assumes: Released pins read 1 through the pull-ups
// Notes: Thermistor state 0 in window, 1 hot, 2 cold, 3 open
`timescale 1ns/1ns
module bcs_host_model (
   input wire logic status_out_a,
   input wire logic status_out_a_oe,
   input wire logic status_out_b,
   input wire logic status_out_b_oe,
   input wire logic [1:0] therm_state,
   output logic pin_a,
   output logic pin_b,
   output logic temp_hot,
   output logic temp_cold,
   output logic ts_float
);
   assign pin_a = status_out_a_oe ? status_out_a : 1'b1;
   assign pin_b = status_out_b_oe ? status_out_b : 1'b1;
   assign temp_hot = (therm_state == 2'h1) || (therm_state == 2'h3); // Open sensor reads too hot
   assign temp_cold = therm_state == 2'h2;
   assign ts_float = therm_state == 2'h3;
endmodule : bcs_host_model

// ### test/test_battery_charge_sequencer.sv
// Purpose: Self-checking bench of the charge sequencer
// Assumes: Minute shortened to 20 cycles, filter to 8 cycles
// Notes: Timer limits checked with two minutes of slack for tick phase
`timescale 1ns/1ns
module test_battery_charge_sequencer;
   localparam int MIN = 20;
   localparam logic [3:0] BE = 4'hF;
   logic core_clk, reset, disable_pin, current_select, pin_a, pin_b, hot, cold, flt;
   logic status_out_a, status_out_a_oe, status_out_b, status_out_b_oe;
   logic charge_on, regulator_mode, usb_high_current, source_is_usb;
   logic [1:0] therm;
   bcs_pkg::bcs_sense_s sense_drv;
   bcs_pkg::bcs_sense_s sense;
   bcs_pkg::bcs_phase_e charge_phase;
   logic [3:0] avs_address, avs_byteenable;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   int error_cnt = 0;
   int tests_run = 0;

   // Thermistor fields come from the board model
   always_comb
   begin
      sense = sense_drv;
      sense.temp_hot = hot;
      sense.temp_cold = cold;
      sense.ts_float = flt;
   end

   bcs_sequencer #(.MINUTE_CYCLES(MIN), .FILTER_CYCLES(8)) bcs_sequencer_i (.core_clk(core_clk), .reset(reset),
      .sense(sense), .disable_pin(disable_pin), .current_select(current_select), .status_out_a(status_out_a),
      .status_out_a_oe(status_out_a_oe), .status_out_b(status_out_b), .status_out_b_oe(status_out_b_oe),
      .charge_on(charge_on), .regulator_mode(regulator_mode), .usb_high_current(usb_high_current),
      .source_is_usb(source_is_usb), .charge_phase(charge_phase), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   bcs_host_model bcs_host_model_i (.status_out_a(status_out_a), .status_out_a_oe(status_out_a_oe),
      .status_out_b(status_out_b), .status_out_b_oe(status_out_b_oe), .therm_state(therm),
      .pin_a(pin_a), .pin_b(pin_b), .temp_hot(hot), .temp_cold(cold), .ts_float(flt));

   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // Compare and report
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Avalon-MM cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [3:0] be, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge core_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= adr;
      avs_byteenable <= be;
      avs_writedata <= wd;
      // Only the watchdog ends a wait that never gets its answer
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // Wait up to n cycles for a phase, then check phase and pin levels
   task automatic go(input bcs_pkg::bcs_phase_e ph, input logic a, input logic b, input int n);
      for (int i = 0; i < n && charge_phase !== ph; i++)
         @(posedge core_clk);
      check("phase_pins", {ph, a, b}, {charge_phase, pin_a, pin_b});
   endtask : go

   // Remove supplies and sensor faults
   task automatic clear;
      @(posedge core_clk);
      sense_drv <= '0;
      therm <= 2'h0;
      go(bcs_pkg::PH_OFF, 1'b1, 1'b1, 10);
   endtask : clear

   task automatic t_reset;
      logic [31:0] rd;
      go(bcs_pkg::PH_OFF, 1'b1, 1'b1, 0);
      bus(1'b0, bcs_pkg::REG_CTRL, BE, 32'h0, rd);
      check("ctrl_reset", 32'h0, rd);
      bus(1'b1, 4'h8, BE, 32'h3, rd);
      bus(1'b0, 4'h8, BE, 32'h0, rd);
      check("unmapped", 32'h0, rd);
      bus(1'b1, bcs_pkg::REG_CTRL, 4'hE, 32'h3, rd);
      bus(1'b0, bcs_pkg::REG_CTRL, BE, 32'h0, rd);
      check("ctrl_be", 32'h0, rd);
      bus(1'b1, bcs_pkg::REG_CTRL, BE, 32'hFFFF_FFFF, rd);
      bus(1'b0, bcs_pkg::REG_CTRL, BE, 32'h0, rd);
      check("ctrl_rw", 32'h3, rd);
      bus(1'b1, bcs_pkg::REG_CTRL, BE, 32'h0, rd);
   endtask : t_reset

   task automatic t_charge;
      @(posedge core_clk);
      sense_drv.wall_ok <= 1'b1;
      go(bcs_pkg::PH_PRE, 1'b0, 1'b1, 8);
      sense_drv.above_fullrate <= 1'b1;
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 8);
      sense_drv.at_term <= 1'b1;
      go(bcs_pkg::PH_CV, 1'b0, 1'b1, 8);
      sense_drv.eoc_reached <= 1'b1;
      go(bcs_pkg::PH_TOP, 1'b0, 1'b1, 8);
      sense_drv.topoff_current <= 1'b1;
      go(bcs_pkg::PH_DONE, 1'b1, 1'b0, 8);
      sense_drv.batt_sagged <= 1'b1;
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 8);
      clear();
   endtask : t_charge

   task automatic t_precond;
      @(posedge core_clk);
      sense_drv.wall_ok <= 1'b1;
      go(bcs_pkg::PH_PRE, 1'b0, 1'b1, 8);
      repeat (20 * MIN) @(posedge core_clk);
      therm <= 2'h1;
      repeat (6) @(posedge core_clk);
      go(bcs_pkg::PH_PRE, 1'b1, 1'b1, 0);
      repeat (50 * MIN) @(posedge core_clk);
      check("suspend_charge", 32'h0, charge_on);
      go(bcs_pkg::PH_PRE, 1'b1, 1'b1, 0);
      therm <= 2'h0;
      repeat (6 * MIN) @(posedge core_clk);
      go(bcs_pkg::PH_PRE, 1'b0, 1'b1, 0);
      go(bcs_pkg::PH_BAD, 1'b0, 1'b0, 14 * MIN);
      disable_pin <= 1'b1;
      repeat (30) @(posedge core_clk);
      go(bcs_pkg::PH_BAD, 1'b0, 1'b0, 0);
      disable_pin <= 1'b0;
      therm <= 2'h2;
      repeat (30) @(posedge core_clk);
      go(bcs_pkg::PH_BAD, 1'b0, 1'b0, 0);
      clear();
   endtask : t_precond

   task automatic t_disable;
      @(posedge core_clk);
      sense_drv.wall_ok <= 1'b1;
      sense_drv.above_fullrate <= 1'b1;
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 16);
      disable_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 0);
      repeat (20) @(posedge core_clk);
      go(bcs_pkg::PH_CC, 1'b1, 1'b1, 0);
      check("disable_charge", 32'h0, charge_on);
      disable_pin <= 1'b0;
      repeat (24) @(posedge core_clk);
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 0);
      clear();
   endtask : t_disable

   task automatic t_topoff(input logic [31:0] ctrl, input int lim);
      logic [31:0] rd;
      bus(1'b1, bcs_pkg::REG_CTRL, BE, ctrl, rd);
      @(posedge core_clk);
      sense_drv.wall_ok <= 1'b1;
      sense_drv.above_fullrate <= 1'b1;
      sense_drv.at_term <= 1'b1;
      sense_drv.eoc_reached <= 1'b1;
      go(bcs_pkg::PH_TOP, 1'b0, 1'b1, 20);
      repeat ((lim - 2) * MIN) @(posedge core_clk);
      go(bcs_pkg::PH_TOP, 1'b0, 1'b1, 0);
      go(bcs_pkg::PH_DONE, 1'b1, 1'b0, 4 * MIN);
      clear();
   endtask : t_topoff

   task automatic t_regulator;
      logic [31:0] rd;
      @(posedge core_clk);
      sense_drv.wall_ok <= 1'b1;
      therm <= 2'h3;
      repeat (8) @(posedge core_clk);
      check("float_plain", 32'h3, {regulator_mode, pin_a, pin_b});
      bus(1'b1, bcs_pkg::REG_CTRL, BE, 32'h2, rd);
      go(bcs_pkg::PH_REG, 1'b0, 1'b0, 8);
      check("reg_mode", 32'h1, regulator_mode);
      sense_drv.wall_ok <= 1'b0;
      sense_drv.bus_ok <= 1'b1;
      repeat (8) @(posedge core_clk);
      check("reg_usb", 32'h3, {regulator_mode, pin_a, pin_b});
      bus(1'b1, bcs_pkg::REG_CTRL, BE, 32'h0, rd);
      clear();
   endtask : t_regulator

   task automatic t_source;
      logic [31:0] rd;
      @(posedge core_clk);
      sense_drv.bus_ok <= 1'b1;
      current_select <= 1'b1;
      repeat (24) @(posedge core_clk);
      check("usb_only", 32'h3, {source_is_usb, usb_high_current});
      bus(1'b0, bcs_pkg::REG_STATUS, BE, 32'h0, rd);
      check("status_usb", 32'h0000_00D1, rd);
      sense_drv.wall_ok <= 1'b1;
      repeat (8) @(posedge core_clk);
      check("both_src", 32'h0, {source_is_usb, usb_high_current});
      clear();
   endtask : t_source

   task automatic t_full(input logic [31:0] ctrl, input int lim);
      logic [31:0] rd;
      bus(1'b1, bcs_pkg::REG_CTRL, BE, ctrl, rd);
      @(posedge core_clk);
      sense_drv.wall_ok <= 1'b1;
      sense_drv.above_fullrate <= 1'b1;
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 16);
      repeat ((lim - 2) * MIN) @(posedge core_clk);
      go(bcs_pkg::PH_CC, 1'b0, 1'b1, 0);
      go(bcs_pkg::PH_BAD, 1'b0, 1'b0, 4 * MIN);
      clear();
   endtask : t_full

   // Watchdog
   initial
   begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      test_done();
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      sense_drv = '0;
      therm = 2'h0;
      disable_pin = 1'b0;
      current_select = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_charge();
      t_precond();
      t_disable();
      t_topoff(32'h0, 30);
      t_regulator();
      t_source();
      t_full(32'h1, 300);
      t_full(32'h0, 300);
      current_select <= 1'b0;
      repeat (24) @(posedge core_clk);
      t_full(32'h1, 600);
      t_topoff(32'h1, 60);
      test_done();
   end
endmodule : test_battery_charge_sequencer
